/* bench/bpp_board.sv */
// Board model: resolves each pad wire from all of its drivers
`timescale 1ns/1ps
`default_nettype none
module bpp_board
    import bpp_pkg::*;
(
    input  wire logic                  clk_in,     // Bench clock
    input  wire bpp_pad_t              pad_in,     // Block pad drive
    input  wire logic [PORT_WIDTH-1:0] ext_en_in,  // Board drives pin
    input  wire logic [PORT_WIDTH-1:0] ext_val_in, // Board level
    output var  logic [PORT_WIDTH-1:0] level_out   // Wire level
);
    logic [PORT_WIDTH-1:0] flt = 8'hA5;
    // Undriven pins wander every cycle
    always @(posedge clk_in) begin
        flt <= ~flt;
    end
    // Block driver, then board driver, then pull-up, else floating
    always_comb begin
        level_out = (pad_in.drive_enable & pad_in.drive_value)
            | (~pad_in.drive_enable & ext_en_in & ext_val_in)
            | (~pad_in.drive_enable & ~ext_en_in & pad_in.pullup_enable)
            | (~pad_in.drive_enable & ~ext_en_in
               & ~pad_in.pullup_enable & flt);
    end
endmodule : bpp_board
`default_nettype wire

/* bench/tb_bidir_port_pin_control.sv */
// Self-checking bench of the bidirectional port pin block
`timescale 1ns/1ps
`default_nettype none
module tb_bidir_port_pin_control;
    import bpp_pkg::*;
    logic          sys_clk_in, rst_n_in, sleep;
    logic          awvalid, wvalid, arvalid;
    logic          awready, wready, bvalid, arready, rvalid, bready;
    logic [7:0]    awaddr, araddr, ext_en, ext_val, int_en, alt_in, smp, lvl;
    logic [31:0]   wdata, rdata;
    logic [1:0]    bresp, rresp;
    bpp_override_t ovr;
    bpp_pad_t      pad;
    logic [7:0]    rows [5][6];
    int            n_mismatch, compares;

    bpp_port dut_u (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .pad_in(lvl),
        .pad_out(pad), .sleep_clamp_in(sleep), .ext_int_en_in(int_en),
        .override_in(ovr), .alt_function_digital_input_out(alt_in),
        .pin_input_sample_out(smp));
    bpp_board board_u (.clk_in(sys_clk_in), .pad_in(pad),
        .ext_en_in(ext_en), .ext_val_in(ext_val), .level_out(lvl));

    // ======================================================
    // Clock and checking helpers
    initial begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic stop_test;
        $display("mismatches=%0d compares=%0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : stop_test

    // ======================================================
    // Bus master: address and data together, hold until taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do @(posedge sys_clk_in); while (awready !== 1'b1);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        while (bvalid !== 1'b1) @(posedge sys_clk_in);
        chk(bresp, er);
    endtask : wr

    task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                        input logic [31:0] m, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge sys_clk_in); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge sys_clk_in);
        chk(rresp, er);
        chk(rdata & m, e);
    endtask : rchk

    // ======================================================
    // Watchdog
    initial begin
        #50000;
        n_mismatch++;
        stop_test();
    end

    // ======================================================
    // Main sequence
    initial begin
        rst_n_in = 1'b0;
        {sleep, awvalid, wvalid, arvalid} = 4'h0;
        bready = 1'b1;
        {awaddr, araddr, ext_en, ext_val, int_en} = 40'h0;
        wdata = 32'h0;
        ovr = '0;
        n_mismatch = 0;
        compares = 0;
        // Direction, latch, disable, driver, drive level, pull-up
        rows = '{'{8'hF0, 8'hCC, 8'h00, 8'hF0, 8'hC0, 8'h0C},
                 '{8'hF0, 8'hCC, 8'h01, 8'hF0, 8'hC0, 8'h00},
                 '{8'h0F, 8'h5A, 8'h00, 8'h0F, 8'h0A, 8'h50},
                 '{8'hFF, 8'h00, 8'h01, 8'hFF, 8'h00, 8'h00},
                 '{8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'hFF}};
        repeat (5) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        @(posedge sys_clk_in);
        #1 chk(pad, '0);
        @(posedge sys_clk_in);
        rchk(ADDR_DIRECTION, PINS_RESET, '1, RESP_OKAY);
        rchk(ADDR_LATCH, PINS_RESET, '1, RESP_OKAY);
        // Pin configuration table, three whole registers written per row
        foreach (rows[i]) begin
            wr(ADDR_CONTROL, 32'(rows[i][2]), RESP_OKAY);
            wr(ADDR_DIRECTION, 32'(rows[i][0]), RESP_OKAY);
            wr(ADDR_LATCH, 32'(rows[i][1]), RESP_OKAY);
            chk(pad.drive_enable, rows[i][3]);
            chk(pad.drive_value & pad.drive_enable, rows[i][4]);
            chk(pad.pullup_enable, rows[i][5]);
            rchk(ADDR_DIRECTION, 32'(rows[i][0]), '1, RESP_OKAY);
            rchk(ADDR_LATCH, 32'(rows[i][1]), '1, RESP_OKAY);
            rchk(ADDR_SAMPLE, 32'(rows[i][4] | rows[i][5]),
                 32'(rows[i][3] | rows[i][5]), RESP_OKAY);
        end
        // Toggle across both directions, zero has no effect
        wr(ADDR_DIRECTION, 32'hF0, RESP_OKAY);
        wr(ADDR_LATCH, 32'h0F, RESP_OKAY);
        wr(ADDR_SAMPLE, 32'h3C, RESP_OKAY);
        wr(ADDR_SAMPLE, 32'h00, RESP_OKAY);
        rchk(ADDR_LATCH, 32'h33, '1, RESP_OKAY);
        // Self-written level visible one period after the write
        wr(ADDR_LATCH, 32'hC3, RESP_OKAY);
        #1 chk(smp & 8'hF0, 8'hC0);
        // Board-driven change seen within one period
        @(posedge sys_clk_in);
        ext_en <= 8'h0F;
        ext_val <= 8'h0A;
        @(posedge sys_clk_in);
        #1 chk(smp, 8'hCA);
        // Sleep clamp, interrupt escape, input override, release
        @(posedge sys_clk_in);
        ext_val <= 8'h0F;
        sleep <= 1'b1;
        int_en <= 8'h05;
        repeat (3) @(posedge sys_clk_in);
        #1 chk(alt_in, 8'h05);
        @(posedge sys_clk_in);
        ovr <= 72'hFF42;
        repeat (3) @(posedge sys_clk_in);
        #1 chk(alt_in, 8'h42);
        @(posedge sys_clk_in);
        ovr <= '0;
        sleep <= 1'b0;
        repeat (3) @(posedge sys_clk_in);
        #1 chk(alt_in, 8'hCF);
        // Pull-up, direction and value overrides
        @(posedge sys_clk_in);
        ovr <= 72'hFF3C0F05FF9A000000;
        repeat (2) @(posedge sys_clk_in);
        #1 chk(pad.pullup_enable, 8'h3C);
        chk(pad.drive_enable, 8'hF5);
        chk(pad.drive_value & pad.drive_enable, 8'h90);
        // One cycle of toggle override inverts the latch once
        @(posedge sys_clk_in);
        ovr <= 72'h810000;
        @(posedge sys_clk_in);
        ovr <= '0;
        @(posedge sys_clk_in);
        rchk(ADDR_LATCH, 32'h42, '1, RESP_OKAY);
        // Unmapped address: error, zero data, no effect
        wr(8'h10, 32'hFF, RESP_SLVERR);
        rchk(8'h10, DATA_ZERO, '1, RESP_SLVERR);
        rchk(ADDR_DIRECTION, 32'hF0, '1, RESP_OKAY);
        // Write response stands while bready is held low
        bready <= 1'b0;
        wr(ADDR_LATCH, 32'h5A, RESP_OKAY);
        repeat (2) @(posedge sys_clk_in);
        chk(bvalid, 1'b1);
        chk(bresp, RESP_OKAY);
        bready <= 1'b1;
        rchk(ADDR_LATCH, 32'h5A, '1, RESP_OKAY);
        // Pull-ups drop while reset is held
        wr(ADDR_DIRECTION, 32'h00, RESP_OKAY);
        wr(ADDR_LATCH, 32'hFF, RESP_OKAY);
        chk(pad.pullup_enable, 8'hFF);
        rst_n_in <= 1'b0;
        @(posedge sys_clk_in);
        #1 chk(pad.pullup_enable, 8'h00);
        @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        @(posedge sys_clk_in);
        rchk(ADDR_LATCH, PINS_RESET, '1, RESP_OKAY);
        stop_test();
    end
endmodule : tb_bidir_port_pin_control
`default_nettype wire

/* design/bpp_pkg.sv */
// Constants, types and register map of the bidirectional port pin block
// Overview of operation
// - Writing one to an input-sample bit inverts that pin's output latch bit.
// - Direction zero, latch zero: input, no pull-up, global disable ignored.
// - Direction zero, latch one, pull-ups allowed: input with pull-up on.
// - Global pull-up disable turns off every pull-up on pins without a pull-up override.
// - Direction one drives the latch value; pull-up is off on pins without a pull-up override.
// - Pin level is readable in the input-sample bit in either direction.
// - Input path: half-cycle latch stage then a rising-edge register.
// - External pin change appears in the sample within half to 1.5 cycles.
// - A software-written level reaches the sample exactly one cycle later.
// - Sleep clamp forces the digital input low in deep sleep on pins without external interrupts enabled.
// - External-interrupt-enabled pins escape the clamp; disabled ones do not.
// - Clamp release on a high pin yields an edge for interrupt logic.
// - Latch-enabled pull-ups are off while reset is active.
// - Alternate functions override pull-up, direction, value, toggle, input.
// - Pull-up follows its override value when enabled, else rule 010.
// - Driver enable follows direction override value when its enable is set.
// - Enabled driver outputs the value override when its enable is set.
// - Input enable follows its override value instead of the sleep clamp.
package bpp_pkg;

    // ======================================================
    // Port geometry
    localparam int PORT_WIDTH = 8;

    // ======================================================
    // Register map, byte addresses of aligned 32-bit words
    localparam logic [7:0] ADDR_DIRECTION = 8'h00; // port_direction_register
    localparam logic [7:0] ADDR_LATCH     = 8'h04; // port_output_latch_register
    localparam logic [7:0] ADDR_SAMPLE    = 8'h08; // port_input_sample_register
    localparam logic [7:0] ADDR_CONTROL   = 8'h0C; // mcu_control_register
    localparam int         ADDR_W         = 8;
    localparam int         CTRL_PU_OFF    = 0;     // global_pullup_disable

    // ======================================================
    // Reset values and bus answers
    localparam logic [PORT_WIDTH-1:0] PINS_RESET = 8'h00;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    localparam logic [31:0] DATA_ZERO   = 32'h00000000;

    // ======================================================
    // Bus handshake states
    typedef enum logic [2:0] {
        BUS_IDLE   = 3'b001,
        BUS_ACCEPT = 3'b010,
        BUS_RESP   = 3'b100
    } bpp_bus_state_t;

    // Per-pin alternate function overrides
    typedef struct packed {
        logic [PORT_WIDTH-1:0] pullup_override_enable;
        logic [PORT_WIDTH-1:0] pullup_override_value;
        logic [PORT_WIDTH-1:0] direction_override_enable;
        logic [PORT_WIDTH-1:0] direction_override_value;
        logic [PORT_WIDTH-1:0] value_override_enable;
        logic [PORT_WIDTH-1:0] value_override_value;
        logic [PORT_WIDTH-1:0] latch_toggle_override_enable;
        logic [PORT_WIDTH-1:0] input_enable_override_enable;
        logic [PORT_WIDTH-1:0] input_enable_override_value;
    } bpp_override_t;

    // Pad drive bundle
    typedef struct packed {
        logic [PORT_WIDTH-1:0] drive_enable;
        logic [PORT_WIDTH-1:0] drive_value;
        logic [PORT_WIDTH-1:0] pullup_enable;
    } bpp_pad_t;

endpackage : bpp_pkg

/* design/bpp_port.sv */
// Bidirectional port pin control with AXI4-Lite register access
`timescale 1ns/1ps
`default_nettype none
module bpp_port
    import bpp_pkg::*;
(
    input  wire logic                  sys_clk_in,     // 100 MHz clock
    input  wire logic                  rst_n_in,       // Sync reset, low
    // AXI4-Lite write address / data / response
    input  wire logic [ADDR_W-1:0]     s_axi_awaddr,   // Write address
    input  wire logic                  s_axi_awvalid,  // Address valid
    output var  logic                  s_axi_awready,  // Address taken
    input  wire logic [31:0]           s_axi_wdata,    // Write data
    input  wire logic [3:0]            s_axi_wstrb,    // Byte enables
    input  wire logic                  s_axi_wvalid,   // Data valid
    output var  logic                  s_axi_wready,   // Data taken
    output var  logic [1:0]            s_axi_bresp,    // Write response
    output var  logic                  s_axi_bvalid,   // Response valid
    input  wire logic                  s_axi_bready,   // Response taken
    // AXI4-Lite read
    input  wire logic [ADDR_W-1:0]     s_axi_araddr,   // Read address
    input  wire logic                  s_axi_arvalid,  // Address valid
    output var  logic                  s_axi_arready,  // Address taken
    output var  logic [31:0]           s_axi_rdata,    // Read data
    output var  logic [1:0]            s_axi_rresp,    // Read response
    output var  logic                  s_axi_rvalid,   // Data valid
    input  wire logic                  s_axi_rready,   // Data taken
    // Pads and system
    input  wire logic [PORT_WIDTH-1:0] pad_in,         // Resolved pad level
    output var  bpp_pad_t              pad_out,        // Drive, oe, pull-up
    input  wire logic                  sleep_clamp_in, // Deep sleep active
    input  wire logic [PORT_WIDTH-1:0] ext_int_en_in,  // Ext irq enabled
    input  wire bpp_override_t         override_in,    // Alt overrides
    output var  logic [PORT_WIDTH-1:0] alt_function_digital_input_out, // Alt in
    output var  logic [PORT_WIDTH-1:0] pin_input_sample_out // Synced pins
);

    // ======================================================
    // State
    bpp_bus_state_t        wr_state, next_wr_state;
    bpp_bus_state_t        rd_state, next_rd_state;
    logic [PORT_WIDTH-1:0] pin_direction_bit, next_pin_direction_bit;
    logic [PORT_WIDTH-1:0] pin_output_latch_bit, next_pin_output_latch_bit;
    logic                  global_pullup_disable, next_global_pullup_disable;
    logic                  awready, next_awready;
    logic                  wready, next_wready;
    logic                  bvalid, next_bvalid;
    logic [1:0]            bresp, next_bresp;
    logic                  arready, next_arready;
    logic                  rvalid, next_rvalid;
    logic [1:0]            rresp, next_rresp;
    logic [31:0]           rdata, next_rdata;
    bpp_pad_t              pad, next_pad;
    logic [PORT_WIDTH-1:0] sync_half;      // Falling-edge stage
    logic [PORT_WIDTH-1:0] sample, next_sample;
    logic [PORT_WIDTH-1:0] digital_in;     // Pad after clamp
    logic [PORT_WIDTH-1:0] input_enable;
    logic [PORT_WIDTH-1:0] wr_mask;
    logic [PORT_WIDTH-1:0] wr_bits;
    logic [31:0]           strb_mask;
    logic                  wr_fire;

    // ======================================================
    // Input path: clamp then two-stage synchroniser
    // Clamp is lifted on pins with external interrupts enabled
    always_comb begin
        input_enable = ~({PORT_WIDTH{sleep_clamp_in}} & ~ext_int_en_in);
        input_enable = (override_in.input_enable_override_enable
                        & override_in.input_enable_override_value)
                     | (~override_in.input_enable_override_enable
                        & input_enable);
        digital_in   = pad_in & input_enable;
    end

    // Closes at the falling edge, like a latch transparent while high
    always_ff @(negedge sys_clk_in) begin
        if (!rst_n_in) begin
            sync_half <= PINS_RESET;
        end else begin
            sync_half <= digital_in;
        end
    end

    // Second stage at the next rising edge
    always_comb begin
        next_sample = sync_half;
    end

    // ======================================================
    // Write data lane masking
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            strb_mask[b*8 +: 8] = {8{s_axi_wstrb[b]}};
        end
        wr_bits = s_axi_wdata[PORT_WIDTH-1:0] & strb_mask[PORT_WIDTH-1:0];
        wr_mask = strb_mask[PORT_WIDTH-1:0];
        wr_fire = (wr_state == BUS_ACCEPT);
    end

    // ======================================================
    // Write channel and pin registers
    always_comb begin
        next_wr_state              = wr_state;
        next_awready               = 1'b0;
        next_wready                = 1'b0;
        next_bvalid                = bvalid;
        next_bresp                 = bresp;
        next_pin_direction_bit     = pin_direction_bit;
        next_pin_output_latch_bit  = pin_output_latch_bit
                                   ^ override_in.latch_toggle_override_enable;
        next_global_pullup_disable = global_pullup_disable;
        case (wr_state)
            BUS_IDLE: begin
                if (s_axi_awvalid && s_axi_wvalid) begin
                    next_awready  = 1'b1;
                    next_wready   = 1'b1;
                    next_wr_state = BUS_ACCEPT;
                end
            end
            BUS_ACCEPT: begin
                next_bresp    = RESP_OKAY;
                next_bvalid   = 1'b1;
                next_wr_state = BUS_RESP;
                if (s_axi_awaddr == ADDR_DIRECTION) begin
                    next_pin_direction_bit = (pin_direction_bit & ~wr_mask)
                                           | wr_bits;
                end else if (s_axi_awaddr == ADDR_LATCH) begin
                    next_pin_output_latch_bit =
                        (pin_output_latch_bit & ~wr_mask) | wr_bits;
                end else if (s_axi_awaddr == ADDR_SAMPLE) begin
                    next_pin_output_latch_bit = next_pin_output_latch_bit
                                              ^ wr_bits;
                end else if (s_axi_awaddr == ADDR_CONTROL) begin
                    if (s_axi_wstrb[0]) begin
                        next_global_pullup_disable =
                            s_axi_wdata[CTRL_PU_OFF];
                    end
                end else begin
                    next_bresp = RESP_SLVERR;
                end
            end
            BUS_RESP: begin
                if (s_axi_bready) begin
                    next_bvalid   = 1'b0;
                    next_wr_state = BUS_IDLE;
                end
            end
            default: begin
                next_wr_state = BUS_IDLE;
            end
        endcase
    end

    // ======================================================
    // Read channel
    always_comb begin
        next_rd_state = rd_state;
        next_arready  = 1'b0;
        next_rvalid   = rvalid;
        next_rresp    = rresp;
        next_rdata    = rdata;
        case (rd_state)
            BUS_IDLE: begin
                if (s_axi_arvalid) begin
                    next_arready  = 1'b1;
                    next_rd_state = BUS_ACCEPT;
                end
            end
            BUS_ACCEPT: begin
                next_rvalid   = 1'b1;
                next_rresp    = RESP_OKAY;
                next_rdata    = DATA_ZERO;
                next_rd_state = BUS_RESP;
                if (s_axi_araddr == ADDR_DIRECTION) begin
                    next_rdata[PORT_WIDTH-1:0] = pin_direction_bit;
                end else if (s_axi_araddr == ADDR_LATCH) begin
                    next_rdata[PORT_WIDTH-1:0] = pin_output_latch_bit;
                end else if (s_axi_araddr == ADDR_SAMPLE) begin
                    next_rdata[PORT_WIDTH-1:0] = sample;
                end else if (s_axi_araddr == ADDR_CONTROL) begin
                    next_rdata[CTRL_PU_OFF] = global_pullup_disable;
                end else begin
                    next_rresp = RESP_SLVERR;
                end
            end
            BUS_RESP: begin
                if (s_axi_rready) begin
                    next_rvalid   = 1'b0;
                    next_rd_state = BUS_IDLE;
                end
            end
            default: begin
                next_rd_state = BUS_IDLE;
            end
        endcase
    end

    // ======================================================
    // Pad control from the values the registers are about to take
    always_comb begin
        next_pad.pullup_enable =
            (override_in.pullup_override_enable
             & override_in.pullup_override_value)
          | (~override_in.pullup_override_enable & ~next_pin_direction_bit
             & next_pin_output_latch_bit
             & ~{PORT_WIDTH{next_global_pullup_disable}});
        next_pad.drive_enable =
            (override_in.direction_override_enable
             & override_in.direction_override_value)
          | (~override_in.direction_override_enable
             & next_pin_direction_bit);
        next_pad.drive_value =
            (override_in.value_override_enable
             & override_in.value_override_value)
          | (~override_in.value_override_enable
             & next_pin_output_latch_bit);
    end

    // ======================================================
    // Registers
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            wr_state              <= BUS_IDLE;
            rd_state              <= BUS_IDLE;
            pin_direction_bit     <= PINS_RESET;
            pin_output_latch_bit  <= PINS_RESET;
            global_pullup_disable <= 1'b0;
            awready               <= 1'b0;
            wready                <= 1'b0;
            bvalid                <= 1'b0;
            bresp                 <= RESP_OKAY;
            arready               <= 1'b0;
            rvalid                <= 1'b0;
            rresp                 <= RESP_OKAY;
            rdata                 <= DATA_ZERO;
            pad                   <= '0;
            sample                <= PINS_RESET;
            alt_function_digital_input_out <= PINS_RESET;
        end else begin
            wr_state              <= next_wr_state;
            rd_state              <= next_rd_state;
            pin_direction_bit     <= next_pin_direction_bit;
            pin_output_latch_bit  <= next_pin_output_latch_bit;
            global_pullup_disable <= next_global_pullup_disable;
            awready               <= next_awready;
            wready                <= next_wready;
            bvalid                <= next_bvalid;
            bresp                 <= next_bresp;
            arready               <= next_arready;
            rvalid                <= next_rvalid;
            rresp                 <= next_rresp;
            rdata                 <= next_rdata;
            pad                   <= next_pad;
            sample                <= next_sample;
            alt_function_digital_input_out <= digital_in;
        end
    end

    // Output wiring
    always_comb begin
        s_axi_awready        = awready;
        s_axi_wready         = wready;
        s_axi_bvalid         = bvalid;
        s_axi_bresp          = bresp;
        s_axi_arready        = arready;
        s_axi_rvalid         = rvalid;
        s_axi_rresp          = rresp;
        s_axi_rdata          = rdata;
        pad_out              = pad;
        pin_input_sample_out = sample;
    end

    // ======================================================
    // Assertions
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    property p_toggle;
        wr_fire && s_axi_awaddr == ADDR_SAMPLE
        && override_in.latch_toggle_override_enable == '0
        |=> pin_output_latch_bit == ($past(pin_output_latch_bit)
                                     ^ $past(wr_bits));
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle lost");

    property p_hiz;
        override_in.pullup_override_enable == '0
        |=> (pad.pullup_enable & ~pin_output_latch_bit) == '0;
    endproperty
    a_hiz: assert property (p_hiz) else $error("pull-up on at 00");

    property p_pullup;
        override_in.pullup_override_enable == '0
        |=> pad.pullup_enable == (~pin_direction_bit & pin_output_latch_bit
             & ~{PORT_WIDTH{global_pullup_disable}});
    endproperty
    a_pullup: assert property (p_pullup) else $error("pull-up wrong");

    property p_pud;
        global_pullup_disable && $past(global_pullup_disable)
        && $past(override_in.pullup_override_enable) == '0
        |-> pad.pullup_enable == '0;
    endproperty
    a_pud: assert property (p_pud) else $error("pull-up not off");

    property p_drive;
        override_in.value_override_enable == '0
        && override_in.direction_override_enable == '0
        |=> pad.drive_enable == pin_direction_bit
            && pad.drive_value == pin_output_latch_bit;
    endproperty
    a_drive: assert property (p_drive) else $error("drive wrong");

    // Falling-edge stage plus rising stage: one rising edge behind
    property p_sync;
        $past(rst_n_in) |-> sample == $past(digital_in);
    endproperty
    a_sync: assert property (p_sync) else $error("sample latency");

    // Clamped pins read low; interrupt-enabled pins are exempt
    property p_clamp;
        sleep_clamp_in && override_in.input_enable_override_enable == '0
        |=> (alt_function_digital_input_out & ~$past(ext_int_en_in)) == '0;
    endproperty
    a_clamp: assert property (p_clamp) else $error("clamp leaked");

    property p_reset;
        disable iff (1'b0) !rst_n_in
        |=> pin_direction_bit == '0 && pin_output_latch_bit == '0
            && pad.pullup_enable == '0;
    endproperty
    a_reset: assert property (p_reset) else $error("reset state");

    property p_bhold;
        bvalid && !s_axi_bready |=> bvalid && $stable(bresp);
    endproperty
    a_bhold: assert property (p_bhold) else $error("bvalid dropped");

    c_toggle: cover property (wr_fire && s_axi_awaddr == ADDR_SAMPLE);
    c_clamp:  cover property (sleep_clamp_in ##1 !sleep_clamp_in);
    c_ovr:    cover property (override_in.direction_override_enable != '0);
    c_read:   cover property (rvalid && s_axi_rready);

endmodule : bpp_port
`default_nettype wire
